/* verilog/pmicp_pkg.sv */
/*
  Constants, register map and packet states of the serial register port
  of a power-management chip. Assumes a 25 MHz system clock.
*/
`default_nettype none
package pmicp_pkg;

  // Clock and spike window; a change counts after GLITCH_CYC+1 samples
  localparam int CLK_PERIOD_NS = 40;
  localparam int GLITCH_NS     = 50;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] GLITCH_CNT_MAX = 3'(GLITCH_CYC);
  localparam int SCL_MAX_KHZ   = 1000;

  // Factory address choices
  localparam logic [6:0] ADDR_OPT0 = 7'h25;
  localparam logic [6:0] ADDR_OPT1 = 7'h27;
  localparam logic [6:0] ADDR_OPT2 = 7'h67;
  localparam logic [6:0] ADDR_OPT3 = 7'h6B;
  localparam logic       DIR_READ  = 1'b1;

  // Bit slots inside one byte plus its acknowledge
  localparam logic [3:0] SLOT_FIRST     = 4'h0;
  localparam logic [3:0] SLOT_BYTE_LAST = 4'h7;
  localparam logic [3:0] SLOT_ACK       = 4'h8;
  localparam logic [3:0] SLOT_ACK_END   = 4'h9;

  // Register map
  localparam int         NV_COUNT    = 4;
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_FMASK   = 8'h01;
  localparam logic [7:0] REG_NV_BASE = 8'h02;
  localparam logic [7:0] REG_PORT    = 8'h06;
  localparam logic [7:0] FMASK_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Write FIFO shape: index byte over data byte
  localparam int WFIFO_WIDTH = 16;
  localparam int WFIFO_DEPTH = 16;

  // Packet states
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_INDEX = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100
  } pmicp_state_t;

endpackage
`default_nettype wire

/* verilog/pmicp_fifo.sv */
/*
  Small synchronous FIFO with a registered output stage.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`default_nettype none
module pmicp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [CW-1:0]    cnt_r;
  wire              push;
  wire              load;

  // Output stage refills whenever empty or being taken
  assign in_ready = (cnt_r != CW'(DEPTH));
  assign push     = in_valid & in_ready;
  assign load     = (cnt_r != '0) & (~out_valid | out_ready);

  // Storage carries no reset to stay a plain memory
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Pointers, level and output register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wp_r      <= '0;
      rp_r      <= '0;
      cnt_r     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (load)
      begin
        rp_r      <= rp_r + 1'b1;
        out_data  <= mem_r[rp_r];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      cnt_r <= cnt_r + CW'(push) - CW'(load);
    end
  end
endmodule
`default_nettype wire

/* verilog/pmicp_port.sv */
/*
  Serial register slave port: spike filter, packet machine, register
  file and a write FIFO toward the chip core.
  Assumes serial pins are asynchronous and chip state inputs share clk_sys.
*/
`default_nettype none
module pmicp_port (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Serial pins
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_n,
  // Chip power states
  input  wire logic                       chip_cold_reset,
  input  wire logic                       deep_low_power_state,
  input  wire logic                       sleep_state,
  input  wire logic                       voltage_fault_retry_state,
  input  wire logic                       thermal_state,
  // Factory straps and defaults
  input  wire logic [1:0]                 factory_configuration_index,
  input  wire logic [pmicp_pkg::NV_COUNT*8-1:0] nv_default_bus,
  // Status and configuration
  input  wire logic [7:0]                 live_status,
  output logic      [7:0]                 fault_out,
  output logic      [pmicp_pkg::NV_COUNT*8-1:0] config_out,
  // Register write stream to the core
  output logic                            reg_wr_valid,
  input  wire logic                       reg_wr_ready,
  output logic      [7:0]                 reg_wr_index,
  output logic      [7:0]                 reg_wr_data
);
  import pmicp_pkg::*;

  // Address lookup for the factory strap
  function automatic logic [6:0] addr_of(input logic [1:0] sel);
    logic [6:0] a;
    a = ADDR_OPT0;
    unique case (sel)
      2'h0: a = ADDR_OPT0;
      2'h1: a = ADDR_OPT1;
      2'h2: a = ADDR_OPT2;
      2'h3: a = ADDR_OPT3;
    endcase
    return a;
  endfunction

  // Line conditioning; index 1 is clock, 0 is data
  wire  [1:0] line_raw;
  wire  [1:0] line_f;
  logic       scl_p_r;
  logic       sda_p_r;

  // Packet machine
  pmicp_state_t state_r, state_nxt;
  logic [3:0] slot_r, slot_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] index_r, index_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic       ack_r, ack_nxt;
  logic       mack_r, mack_nxt;
  logic       oe_n_nxt;

  // Registers
  logic [1:0]          fci_r;
  logic [7:0]          mask_r;
  logic [NV_COUNT*8-1:0] nv_r;

  // FIFO wiring
  wire        fifo_in_ready;
  wire [15:0] fifo_out;
  wire        reg_commit;

  assign line_raw = {scl_in, sda_in};

  // Two-stage sync then persistence filter per line
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      logic       m_r;
      logic       s_r;
      logic       f_r;
      logic [2:0] c_r;
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          m_r <= 1'b1;
          s_r <= 1'b1;
          f_r <= 1'b1;
          c_r <= 3'h0;
        end
        else
        begin
          m_r <= line_raw[g];
          s_r <= m_r;
          if (s_r == f_r)
            c_r <= 3'h0;
          else if (c_r == GLITCH_CNT_MAX)
          begin
            f_r <= s_r;
            c_r <= 3'h0;
          end
          else
            c_r <= c_r + 3'h1;
        end
      end
      assign line_f[g] = f_r;
    end
  endgenerate

  // Edge and condition decode; both lines share one delay, so
  // setup and hold relations survive the filter at 1 MHz
  wire scl_f    = line_f[1];
  wire sda_f    = line_f[0];
  wire scl_rise = scl_f & ~scl_p_r;
  wire scl_fall = ~scl_f & scl_p_r;
  wire start_ev = scl_f & scl_p_r & sda_p_r & ~sda_f;
  wire stop_ev  = scl_f & scl_p_r & ~sda_p_r & sda_f;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
    end
  end

  // Port control decode
  wire       port_dead = chip_cold_reset;
  wire       fsm_clear = port_dead | deep_low_power_state | sleep_state
                         | voltage_fault_retry_state | thermal_state;
  wire [6:0] own_addr  = addr_of(fci_r);
  wire [7:0] rx_byte   = {shift_r[6:0], sda_f};
  wire       addr_hit  = (rx_byte[7:1] == own_addr);
  wire       rd_dir    = (shift_r[0] == DIR_READ);
  wire       wdata_push = (state_r == ST_WDATA) & scl_rise
                          & (slot_r == SLOT_BYTE_LAST) & fifo_in_ready;
  wire       byte_ack  = (state_r == ST_ADDR)  ? addr_hit :
                         (state_r == ST_INDEX) ? 1'b1 :
                         (state_r == ST_WDATA) ? fifo_in_ready : 1'b0;

  // Read multiplexer; status is the live input, not a copy
  wire [7:0] nv_sel_idx = index_r - REG_NV_BASE;
  wire       nv_hit     = (index_r >= REG_NV_BASE)
                          & (nv_sel_idx < 8'(NV_COUNT));
  wire [7:0] port_stat  = {5'h00, state_r};
  wire [7:0] rd_byte    = (index_r == REG_STATUS) ? live_status :
                          (index_r == REG_FMASK)  ? mask_r :
                          (index_r == REG_PORT)   ? port_stat :
                          nv_hit ? nv_r[nv_sel_idx[1:0]*8 +: 8] : UNMAPPED_RD;

  // Packet sequencing; nothing here counts idle time, so a stalled
  // packet waits for start, stop or a state clear
  always_comb
  begin
    state_nxt = state_r;
    slot_nxt  = slot_r;
    shift_nxt = shift_r;
    index_nxt = index_r;
    tx_nxt    = tx_r;
    ack_nxt   = ack_r;
    mack_nxt  = mack_r;
    oe_n_nxt  = sda_oe_n;
    if (fsm_clear)
    begin
      state_nxt = ST_IDLE;
      slot_nxt  = SLOT_FIRST;
      oe_n_nxt  = 1'b1;
    end
    else if (start_ev)
    begin
      state_nxt = ST_ADDR;
      slot_nxt  = SLOT_FIRST;
      oe_n_nxt  = 1'b1;
    end
    else if (stop_ev)
    begin
      state_nxt = ST_IDLE;
      slot_nxt  = SLOT_FIRST;
      oe_n_nxt  = 1'b1;
    end
    else if (state_r != ST_IDLE)
    begin
      if (scl_rise)
      begin
        slot_nxt = slot_r + 4'h1;
        if (slot_r < SLOT_ACK)
          shift_nxt = rx_byte;
        if (slot_r == SLOT_BYTE_LAST)
          ack_nxt = byte_ack;
        if (slot_r == SLOT_ACK)
          mack_nxt = ~sda_f;
      end
      else if (scl_fall)
      begin
        if (slot_r == SLOT_ACK)
        begin
          // Host owns the line for its own acknowledge on reads
          oe_n_nxt = (state_r == ST_RDATA) ? 1'b1 : ~ack_r;
          if (state_r == ST_RDATA)
            index_nxt = index_r + 8'h01;
        end
        else if (slot_r == SLOT_ACK_END)
        begin
          slot_nxt = SLOT_FIRST;
          oe_n_nxt = 1'b1;
          unique case (state_r)
            ST_ADDR:
            begin
              if (!ack_r)
                state_nxt = ST_IDLE;
              else if (rd_dir)
              begin
                state_nxt = ST_RDATA;
                tx_nxt    = rd_byte;
                oe_n_nxt  = rd_byte[7];
              end
              else
                state_nxt = ST_INDEX;
            end
            ST_INDEX:
            begin
              index_nxt = shift_r;
              state_nxt = ST_WDATA;
            end
            ST_WDATA:
            begin
              if (ack_r)
                index_nxt = index_r + 8'h01;
              else
                state_nxt = ST_IDLE;
            end
            ST_RDATA:
            begin
              if (mack_r)
              begin
                tx_nxt   = rd_byte;
                oe_n_nxt = rd_byte[7];
              end
              else
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
          endcase
        end
        else if (state_r == ST_RDATA)
        begin
          oe_n_nxt = tx_r[6];
          tx_nxt   = {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Packet state registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_r  <= ST_IDLE;
      slot_r   <= SLOT_FIRST;
      shift_r  <= 8'h00;
      index_r  <= 8'h00;
      tx_r     <= 8'h00;
      ack_r    <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      state_r  <= state_nxt;
      slot_r   <= slot_nxt;
      shift_r  <= shift_nxt;
      index_r  <= index_nxt;
      tx_r     <= tx_nxt;
      ack_r    <= ack_nxt;
      mack_r   <= mack_nxt;
      sda_oe_n <= oe_n_nxt;
    end
  end

  // Open-drain: the driven level is always low
  always_ff @(posedge clk_sys)
  begin
    sda_out <= 1'b0;
  end

  // Written bytes queue here so a slow core can stall the host by NACK
  pmicp_fifo #(
    .WIDTH (WFIFO_WIDTH),
    .DEPTH (WFIFO_DEPTH)
  ) u_wfifo (
    .clk_sys   (clk_sys),
    .rst       (rst | port_dead),
    .in_valid  (wdata_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({index_r, rx_byte}),
    .out_valid (reg_wr_valid),
    .out_ready (reg_wr_ready),
    .out_data  (fifo_out)
  );

  assign reg_wr_index = fifo_out[15:8];
  assign reg_wr_data  = fifo_out[7:0];
  assign reg_commit   = reg_wr_valid & reg_wr_ready;

  // Strap capture and volatile mask; status index has no write path
  always_ff @(posedge clk_sys)
  begin
    if (rst | port_dead)
    begin
      fci_r  <= factory_configuration_index;
      mask_r <= FMASK_RST;
    end
    else if (reg_commit & (reg_wr_index == REG_FMASK))
      mask_r <= reg_wr_data;
  end

  // Non-volatile registers reload the factory image on cold reset
  generate
    for (g = 0; g < NV_COUNT; g++)
    begin : g_nv
      wire hit = reg_commit & (reg_wr_index == REG_NV_BASE + 8'(g));
      always_ff @(posedge clk_sys)
      begin
        if (rst | port_dead)
          nv_r[g*8 +: 8] <= nv_default_bus[g*8 +: 8];
        else if (hit)
          nv_r[g*8 +: 8] <= reg_wr_data;
      end
    end
  endgenerate

  assign config_out = nv_r;

  // Dedicated fault outputs follow live status through the mask
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      fault_out <= 8'h00;
    else
      fault_out <= live_status & ~mask_r;
  end
endmodule
`default_nettype wire

/* tb/pmicp_port_checker.sv */
/*
  Checker of the serial register port: pins, resets and write stream.
  Assumes a bind into pmicp_port and the single clk_sys domain.
*/
`default_nettype none
module pmicp_port_checker (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Serial pins
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Chip states
  input wire logic       chip_cold_reset,
  input wire logic       deep_low_power_state,
  input wire logic       sleep_state,
  input wire logic       voltage_fault_retry_state,
  input wire logic       thermal_state,
  // Defaults, status and write stream
  input wire logic [pmicp_pkg::NV_COUNT*8-1:0] nv_default_bus,
  input wire logic [7:0] live_status,
  input wire logic [7:0] fault_out,
  input wire logic [pmicp_pkg::NV_COUNT*8-1:0] config_out,
  input wire logic       reg_wr_valid,
  input wire logic       reg_wr_ready,
  input wire logic [7:0] reg_wr_index,
  input wire logic [7:0] reg_wr_data
);
  import pmicp_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Any state other than cold reset that clears the packet machine
  wire logic clr_any = deep_low_power_state | sleep_state | voltage_fault_retry_state
                       | thermal_state;

  // Pin behaviour; drive may only start well into the clock low phase
  a_drive_low: assert property (sda_out == 1'b0)
    else $error("data drive value high");
  a_cold_quiet: assert property (chip_cold_reset [*2] |-> sda_oe_n)
    else $error("data pulled in cold reset");
  a_state_quiet: assert property (clr_any [*3] |-> sda_oe_n)
    else $error("data pulled in clearing state");
  a_ack_clk_low: assert property ($fell(sda_oe_n) |-> !scl_in && !$past(scl_in, 4))
    else $error("drive began outside clock low");

  // Defaults and the write stream
  a_cold_dflt: assert property (chip_cold_reset |=> config_out == $past(nv_default_bus))
    else $error("config not at defaults");
  a_cold_flush: assert property (chip_cold_reset |=> !reg_wr_valid)
    else $error("word kept over cold reset");
  a_word_holds: assert property (reg_wr_valid && !reg_wr_ready && !chip_cold_reset
      |=> reg_wr_valid && $stable({reg_wr_index, reg_wr_data}))
    else $error("queued word changed");
  a_fault_mask: assert property ((fault_out & ~$past(live_status)) == 8'h00)
    else $error("fault not in live status");
  a_reset_idle: assert property (@(posedge clk_sys) disable iff (1'b0)
      rst |=> sda_oe_n && !reg_wr_valid && fault_out == 8'h00)
    else $error("outputs not idle after reset");

  // Main scenarios reached
  c_ack: cover property ($fell(sda_oe_n));
  c_taken: cover property (reg_wr_valid && reg_wr_ready);
  c_stalled: cover property ((reg_wr_valid && !reg_wr_ready) [*8]);
  c_cold: cover property (chip_cold_reset ##1 !chip_cold_reset);
endmodule

bind pmicp_port pmicp_port_checker pmicp_port_checker_i (
  .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .chip_cold_reset(chip_cold_reset),
  .deep_low_power_state(deep_low_power_state), .sleep_state(sleep_state),
  .voltage_fault_retry_state(voltage_fault_retry_state),
  .thermal_state(thermal_state), .nv_default_bus(nv_default_bus),
  .live_status(live_status), .fault_out(fault_out), .config_out(config_out),
  .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
  .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data)
);
`default_nettype wire

/* tb/pmicp_host.sv */
/*
  Bus host model: bit-level start, stop and byte tasks.
  Assumes the bench resolves the data line with a pull-up.
*/
`default_nettype none
module pmicp_host (
  // Serial lines
  output var logic  scl,
  output var logic  sda_low,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One 1 us bit slot; data moves only while the clock is low
  task automatic bit_x(input logic b, output logic r);
    #200 sda_low = !b;
    #480 scl = 1'b1;
    #300 r = sda_line;
    #20 scl = 1'b0;
  endtask

  // Start or repeated start, and stop
  task automatic start();
    #200 sda_low = 1'b0;
    #480 scl = 1'b1;
    #320 sda_low = 1'b1;
    #320 scl = 1'b0;
  endtask
  task automatic stop();
    #200 sda_low = 1'b1;
    #480 scl = 1'b1;
    #320 sda_low = 1'b0;
  endtask

  // 40 ns clock pulse inside a low phase
  task automatic spike();
    #200 scl = 1'b1;
    #40 scl = 1'b0;
  endtask

  // Bytes go most significant bit first, answer bit after
  task automatic send8(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ak = !r;
  endtask
  task automatic recv8(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule
`default_nettype wire

/* tb/tb_pmicp_port.sv */
/*
  Self-checking bench of the serial register port.
  Assumes the host model and the checker bind are compiled first.
*/
`default_nettype none
module tb_pmicp_port;
  timeunit 1ns;
  timeprecision 1ns;
  import pmicp_pkg::*;

  // Pins and bench state
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic                  chip_cold_reset = 1'b0;
  logic [3:0]            pst = 4'h0;
  logic [1:0]            fidx = 2'h0;
  logic [7:0]            live_status = 8'h00;
  logic                  reg_wr_ready = 1'b0;
  logic                  hold = 1'b0;
  logic                  scl, sda_low, sda_out, sda_oe_n, reg_wr_valid, ak;
  logic [7:0]            fault_out, reg_wr_index, reg_wr_data, mask_m, d;
  logic [NV_COUNT*8-1:0] config_out, nv_m, nv_def;
  wire logic             sda_line;
  int                    seed = 32'h2313;
  int                    miscompares = 0;
  int                    checks_done = 0;
  logic [15:0]           exp_q[$];
  logic [15:0]           w;
  logic [2:0]            a3;
  logic [6:0]            ad;
  logic [6:0]            addrs[4] = '{7'h25, 7'h27, 7'h67, 7'h6B};

  pmicp_port pmicp_port_i (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_cold_reset(chip_cold_reset),
    .deep_low_power_state(pst[0]), .sleep_state(pst[1]),
    .voltage_fault_retry_state(pst[2]), .thermal_state(pst[3]),
    .factory_configuration_index(fidx), .nv_default_bus(nv_def),
    .live_status(live_status), .fault_out(fault_out), .config_out(config_out),
    .reg_wr_valid(reg_wr_valid), .reg_wr_ready(reg_wr_ready),
    .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data));
  pmicp_host pmicp_host_i (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

  // Open-drain wire with pull-up; either side may pull low
  assign sda_line = !sda_low && (sda_oe_n || sda_out);
  always #20 clk_sys = !clk_sys;

  // Core stalls at random, or fully while hold is set
  always @(posedge clk_sys)
    reg_wr_ready <= #1 !hold && 1'($random(seed));

  // Every taken word must be the next expected one; models follow it
  always @(posedge clk_sys)
    if (reg_wr_valid === 1'b1 && reg_wr_ready === 1'b1)
    begin
      w = exp_q.size() != 0 ? exp_q.pop_front() : 16'hXXXX;
      check({reg_wr_index, reg_wr_data}, w);
      if (w[15:8] == 8'h01)
        mask_m = w[7:0];
      if (w[15:8] >= 8'h02 && w[15:8] <= 8'h05)
        nv_m[int'(w[15:8] - 8'h02) * 8 +: 8] = w[7:0];
    end

  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] fault_exp(input logic [7:0] s, m);
    return s & ~m;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Packet pieces; answers land in ak and a3
  task automatic hs(input logic [7:0] b);
    pmicp_host_i.send8(b, ak);
  endtask
  task automatic opn(input logic [6:0] a, input logic [7:0] i);
    pmicp_host_i.start();
    hs({a, 1'b0});
    a3[2] = ak;
    hs(i);
    a3[1] = ak;
  endtask
  task automatic wr1(input logic [6:0] a, input logic [7:0] i, b);
    opn(a, i);
    hs(b);
    a3[0] = ak;
    pmicp_host_i.stop();
  endtask
  task automatic rd1(input logic [6:0] a, input logic [7:0] i);
    opn(a, i);
    pmicp_host_i.start();
    hs({a, 1'b1});
    pmicp_host_i.recv8(d, 1'b1);
    pmicp_host_i.stop();
  endtask
  task automatic drain();
    for (int n = 0; n < 4000 && exp_q.size() != 0; n++)
      @(posedge clk_sys);
    tick(4);
    check(32'(exp_q.size()), 32'h0);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nv_def = $random(seed);
    live_status = 8'($random(seed));
    tick(16);
    rst = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      fidx = 2'(k);
      chip_cold_reset = 1'b1;
      tick(2);
      chip_cold_reset = 1'b0;
      nv_m = nv_def;
      mask_m = 8'h00;
      tick(8);
      check(config_out, nv_def);
      d = 8'($random(seed));
      wr1(addrs[(k + 1) % 4], 8'h02, d);
      check(a3, 3'b000);
      exp_q.push_back({8'h02 + 8'(k), d});
      wr1(addrs[k], 8'h02 + 8'(k), d);
      check(a3, 3'b111);
      drain();
      check(config_out, nv_m);
    end
    ad = addrs[3];
    rd1(ad, 8'h01);
    check(d, mask_m);
    d = d | 8'($random(seed));
    exp_q.push_back({8'h01, d});
    wr1(ad, 8'h01, d);
    drain();
    tick(3);
    check(fault_out, fault_exp(live_status, mask_m));
    exp_q.push_back({8'h00, 8'hFF});
    wr1(ad, 8'h00, 8'hFF);
    drain();
    live_status = 8'($random(seed));
    rd1(ad, 8'h00);
    check(d, live_status);
    for (int j = 0; j < 4; j++)
    begin
      rd1(ad, 8'h02 + 8'(j));
      check(d, nv_m[j * 8 +: 8]);
    end
    // Burst read over the last NV byte, port state and an unmapped index
    opn(ad, 8'h05);
    pmicp_host_i.start();
    hs({ad, 1'b1});
    pmicp_host_i.recv8(d, 1'b0);
    check(d, nv_m[31:24]);
    pmicp_host_i.recv8(d, 1'b0);
    check(d, {5'h00, ST_RDATA});
    pmicp_host_i.recv8(d, 1'b1);
    check(d, UNMAPPED_RD);
    pmicp_host_i.stop();
    // Start in mid-byte drops the open packet
    opn(ad, 8'h03);
    repeat (3) pmicp_host_i.bit_x(1'b0, ak);
    d = 8'($random(seed));
    exp_q.push_back({8'h04, d});
    wr1(ad, 8'h04, d);
    check(a3, 3'b111);
    drain();
    // Long stall and a clock spike inside one packet
    d = 8'($random(seed));
    exp_q.push_back({8'h05, d});
    opn(ad, 8'h05);
    tick(2000);
    pmicp_host_i.spike();
    hs(d);
    pmicp_host_i.stop();
    check(ak, 1'b1);
    drain();
    // Each clearing state kills the open packet
    for (int j = 0; j < 4; j++)
    begin
      opn(ad, 8'h02);
      pst = 4'(1 << j);
      tick(3);
      pst = 4'h0;
      hs(8'hA5);
      pmicp_host_i.stop();
      check(ak, 1'b0);
    end
    drain();
    // Port is dead while cold reset is held
    chip_cold_reset = 1'b1;
    wr1(ad, 8'h02, 8'h3C);
    check(a3, 3'b000);
    check(config_out, nv_def);
    mask_m = FMASK_RST;
    check(fault_out, fault_exp(live_status, mask_m));
    chip_cold_reset = 1'b0;
    nv_m = nv_def;
    // Stalled core: 17 words fit, the next is refused
    hold = 1'b1;
    opn(ad, 8'h02);
    for (int j = 0; j < 18; j++)
    begin
      d = 8'($random(seed));
      if (j < 17)
        exp_q.push_back({8'h02 + 8'(j), d});
      hs(d);
      check(ak, j < 17);
    end
    pmicp_host_i.stop();
    hold = 1'b0;
    drain();
    check(config_out, nv_m);
    give_verdict();
  end

  // Hang guard at about three times the expected run
  initial
  begin
    #3_000_000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
